// *** rtl/pirq_flag_bank.sv ***
`timescale 1ns/1ps
`include "pirq_consts.svh"
// Functional notes
// R01: Each flag sets when its source event occurs, regardless of any enable bit.
// R02: Software should clear a flag before enabling that interrupt.
// R03: Flag register 1 holds timer1 gate, converter, serial rx, serial tx, sync port1, capture1, timer2, timer1 ovf.
// R04: The serial rx and tx flags at bits 5 and 4 are read-only and ignore writes.
// R05: Flag register 2 holds osc fail, comp2, comp1, eeprom done, port1 collision at bits 7..3; bits 2-1 read zero.
// R06: Bit 0 of flag register 2 is the capture2 flag, present on the large variant only.
// R07: Flag register 3 holds capture4, capture3, timer6, timer4 at bits 5,4,3,1; others read zero.
// R08: Flag registers 3 and 4 exist only on the large variant.
// R09: Every implemented flag clears to zero on any reset.
// R10: A one means pending, a zero means idle, and a flag holds until software clears it.
// R11: Flag register 4 holds port2 collision at bit 1 and sync port2 at bit 0; bits 7-2 read zero.
// R12: Software must set the peripheral enable in the global control before any interrupt is raised.
// R13: A set event in the same cycle as a software clear wins, so no event is lost.
module pirq_flag_bank #(
    parameter bit LARGE_VARIANT = 1'b1
) (
    // Clock and reset.
    input  wire logic                     mclk_i,
    input  wire logic                     rst_i,
    // Register port.
    input  wire logic [`PIRQ_ADDR_W-1:0]  addr_i,
    input  wire logic [7:0]               wdata_i,
    input  wire logic                     wr_i,
    input  wire logic                     rd_i,
    output logic      [7:0]               rdata_o,
    // Peripheral event pulses, one bit per flag position.
    input  wire logic [7:0]               evt1_i,
    input  wire logic [7:0]               evt2_i,
    input  wire logic [7:0]               evt3_i,
    input  wire logic [7:0]               evt4_i,
    // Global gating and interrupt.
    input  wire logic                     peripheral_irq_enable_i,
    output logic                          irq_o
);

    logic [7:0]           flags_reg [4];
    logic [7:0]           mask_reg [4];
    logic [3:0]           pend_bits;
    pirq_pkg::pirq_bank_t impl;
    pirq_pkg::pirq_bank_t wmask;
    pirq_pkg::pirq_bank_t evt;
    logic [7:0]           rdata_next;
    logic                 is_flag;
    logic [1:0]           idx;

    // Named views of the individual request flags.
    logic                 timer1_gate_flag;
    logic                 converter_done_flag;
    logic                 serial_rx_flag;
    logic                 serial_tx_flag;
    logic                 sync_port1_flag;
    logic                 capture_unit1_flag;
    logic                 timer2_match_flag;
    logic                 timer1_overflow_flag;
    logic                 osc_fail_flag;
    logic                 comparator2_flag;
    logic                 comparator1_flag;
    logic                 eeprom_write_done_flag;
    logic                 port1_collision_flag;
    logic                 capture_unit2_flag;
    logic                 capture_unit4_flag;
    logic                 capture_unit3_flag;
    logic                 timer6_match_flag;
    logic                 timer4_match_flag;
    logic                 port2_collision_flag;
    logic                 sync_port2_flag;

    // Which bits physically exist depends on the variant.
    always_comb begin
        impl[0] = `PIRQ_IMPL1_LARGE;                                             // [R03]
        impl[1] = LARGE_VARIANT ? `PIRQ_IMPL2_LARGE : `PIRQ_IMPL2_SMALL;          // [R05] [R06]
        impl[2] = LARGE_VARIANT ? `PIRQ_IMPL3_LARGE : `PIRQ_IMPL_NONE;            // [R07] [R08]
        impl[3] = LARGE_VARIANT ? `PIRQ_IMPL4_LARGE : `PIRQ_IMPL_NONE;            // [R11] [R08]
        wmask    = impl;
        wmask[0] = impl[0] & ~`PIRQ_RO1;                                         // [R04]
        evt[0]  = evt1_i;
        evt[1]  = evt2_i;
        evt[2]  = evt3_i;
        evt[3]  = evt4_i;
    end

    assign is_flag = (addr_i[2] == 1'b0);
    assign idx     = addr_i[1:0];

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_reg
            logic [7:0] clr;
            // Write-one-to-clear on flag registers; read-only bits never take part in a clear.
            assign clr = (wr_i && is_flag && idx == 2'(g)) ? (wdata_i & wmask[g]) : 8'h00;
            assign pend_bits[g] = |(flags_reg[g] & mask_reg[g]);

            // Hardware events set regardless of masks; set wins over clear.
            always_ff @(posedge mclk_i or posedge rst_i) begin
                if (rst_i) begin
                    flags_reg[g] <= `PIRQ_FLAGS_RST;                             // [R09]
                end else begin
                    flags_reg[g] <= ((flags_reg[g] & ~clr) | evt[g]) & impl[g];  // [R01] [R10] [R13]
                end
            end

            always_ff @(posedge mclk_i or posedge rst_i) begin
                if (rst_i) begin
                    mask_reg[g] <= `PIRQ_MASK_RST;
                end else if (wr_i && !is_flag && idx == 2'(g)) begin
                    mask_reg[g] <= wdata_i & impl[g];
                end
            end

            // A flag must follow its event by one cycle.
            flag_set_a: assert property (@(posedge mclk_i) disable iff (rst_i) // [R01]
                (evt[g] & impl[g]) != 8'h00 |=> (flags_reg[g] & $past(evt[g] & impl[g])) == $past(evt[g] & impl[g]))
                else $error("Event did not set its flag.");

            // Absent bits never read one.
            flag_impl_a: assert property (@(posedge mclk_i) disable iff (rst_i) // [R05]
                (flags_reg[g] & ~impl[g]) == 8'h00)
                else $error("Unimplemented flag bit set.");

            // With no write and no event a flag holds.
            flag_hold_a: assert property (@(posedge mclk_i) disable iff (rst_i) // [R10]
                !wr_i && evt[g] == 8'h00 |=> flags_reg[g] == $past(flags_reg[g]))
                else $error("Flag changed without cause.");
        end
    endgenerate

    // Read data stand for one cycle after the strobe and are zero otherwise.
    always_comb begin
        rdata_next = 8'h00;
        if (rd_i) begin
            rdata_next = is_flag ? flags_reg[idx] : mask_reg[idx];
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= 8'h00;
        end else begin
            rdata_o <= rdata_next;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= peripheral_irq_enable_i && (pend_bits != 4'h0);  // [R12]
        end
    end

    ro_bits_a: assert property (@(posedge mclk_i) disable iff (rst_i) // [R04]
        wr_i && addr_i == `PIRQ_OFF_FLAGS1 && evt1_i == 8'h00 && flags_reg[0][`PIRQ_B1_SER_RX]
        |=> flags_reg[0][`PIRQ_B1_SER_RX])
        else $error("Read-only receive flag was cleared.");

    set_wins_a: assert property (@(posedge mclk_i) disable iff (rst_i) // [R13]
        wr_i && addr_i == `PIRQ_OFF_FLAGS1 && evt1_i[`PIRQ_B1_TMR1_GATE]
        |=> flags_reg[0][`PIRQ_B1_TMR1_GATE])
        else $error("Set lost against clear.");

    w1c_a: assert property (@(posedge mclk_i) disable iff (rst_i) // [R10]
        wr_i && addr_i == `PIRQ_OFF_FLAGS1 && wdata_i[`PIRQ_B1_CONV_DONE] == 1'b1 && !evt1_i[`PIRQ_B1_CONV_DONE]
        |=> !flags_reg[0][`PIRQ_B1_CONV_DONE])
        else $error("Converter flag not cleared.");

    rd_data_a: assert property (@(posedge mclk_i) disable iff (rst_i) // [R03]
        rd_i && addr_i == `PIRQ_OFF_FLAGS1 |=> rdata_o == $past(flags_reg[0]))
        else $error("Read data mismatch.");

    irq_gate_a: assert property (@(posedge mclk_i) disable iff (rst_i) // [R12]
        !peripheral_irq_enable_i |=> !irq_o)
        else $error("Interrupt raised without peripheral enable.");

    small_var_a: assert property (@(posedge mclk_i) disable iff (rst_i) // [R08]
        !LARGE_VARIANT |-> flags_reg[2] == 8'h00 && flags_reg[3] == 8'h00 && !flags_reg[1][`PIRQ_B2_CAP2])
        else $error("Large-variant flag present on small variant.");

    // Named views of the individual request flags.
    assign timer1_gate_flag       = flags_reg[0][`PIRQ_B1_TMR1_GATE];
    assign converter_done_flag    = flags_reg[0][`PIRQ_B1_CONV_DONE];
    assign serial_rx_flag         = flags_reg[0][`PIRQ_B1_SER_RX];
    assign serial_tx_flag         = flags_reg[0][`PIRQ_B1_SER_TX];
    assign sync_port1_flag        = flags_reg[0][`PIRQ_B1_SYNC1];
    assign capture_unit1_flag     = flags_reg[0][`PIRQ_B1_CAP1];
    assign timer2_match_flag      = flags_reg[0][`PIRQ_B1_TMR2];
    assign timer1_overflow_flag   = flags_reg[0][`PIRQ_B1_TMR1_OVF];
    assign osc_fail_flag          = flags_reg[1][`PIRQ_B2_OSC_FAIL];
    assign comparator2_flag       = flags_reg[1][`PIRQ_B2_CMP2];
    assign comparator1_flag       = flags_reg[1][`PIRQ_B2_CMP1];
    assign eeprom_write_done_flag = flags_reg[1][`PIRQ_B2_EE_DONE];
    assign port1_collision_flag   = flags_reg[1][`PIRQ_B2_COLL1];
    assign capture_unit2_flag     = flags_reg[1][`PIRQ_B2_CAP2];
    assign capture_unit4_flag     = flags_reg[2][`PIRQ_B3_CAP4];
    assign capture_unit3_flag     = flags_reg[2][`PIRQ_B3_CAP3];
    assign timer6_match_flag      = flags_reg[2][`PIRQ_B3_TMR6];
    assign timer4_match_flag      = flags_reg[2][`PIRQ_B3_TMR4];
    assign port2_collision_flag   = flags_reg[3][`PIRQ_B4_COLL2];
    assign sync_port2_flag        = flags_reg[3][`PIRQ_B4_SYNC2];

    // Each source of the first register lands on its own bit.
    gate_set_a: assert property (@(posedge mclk_i) disable iff (rst_i) // [R03]
        evt1_i[`PIRQ_B1_TMR1_GATE] |=> timer1_gate_flag)
        else $error("Timer1 gate flag not set.");

    conv_set_a: assert property (@(posedge mclk_i) disable iff (rst_i) // [R03]
        evt1_i[`PIRQ_B1_CONV_DONE] |=> converter_done_flag)
        else $error("Converter flag not set.");

    rx_set_a: assert property (@(posedge mclk_i) disable iff (rst_i) // [R03]
        evt1_i[`PIRQ_B1_SER_RX] |=> serial_rx_flag)
        else $error("Serial receive flag not set.");

    tx_set_a: assert property (@(posedge mclk_i) disable iff (rst_i) // [R03]
        evt1_i[`PIRQ_B1_SER_TX] |=> serial_tx_flag)
        else $error("Serial transmit flag not set.");

    sync1_set_a: assert property (@(posedge mclk_i) disable iff (rst_i) // [R03]
        evt1_i[`PIRQ_B1_SYNC1] |=> sync_port1_flag)
        else $error("Sync port 1 flag not set.");

    cap1_set_a: assert property (@(posedge mclk_i) disable iff (rst_i) // [R03]
        evt1_i[`PIRQ_B1_CAP1] |=> capture_unit1_flag)
        else $error("Capture 1 flag not set.");

    match2_set_a: assert property (@(posedge mclk_i) disable iff (rst_i) // [R03]
        evt1_i[`PIRQ_B1_TMR2] |=> timer2_match_flag)
        else $error("Timer2 match flag not set.");

    ovf_set_a: assert property (@(posedge mclk_i) disable iff (rst_i) // [R03]
        evt1_i[`PIRQ_B1_TMR1_OVF] |=> timer1_overflow_flag)
        else $error("Timer1 overflow flag not set.");

    // Sources of the second register; the capture 2 bit only exists on the large variant.
    osc_set_a: assert property (@(posedge mclk_i) disable iff (rst_i) // [R05]
        evt2_i[`PIRQ_B2_OSC_FAIL] |=> osc_fail_flag)
        else $error("Oscillator fail flag not set.");

    cmp2_set_a: assert property (@(posedge mclk_i) disable iff (rst_i) // [R05]
        evt2_i[`PIRQ_B2_CMP2] |=> comparator2_flag)
        else $error("Comparator 2 flag not set.");

    cmp1_set_a: assert property (@(posedge mclk_i) disable iff (rst_i) // [R05]
        evt2_i[`PIRQ_B2_CMP1] |=> comparator1_flag)
        else $error("Comparator 1 flag not set.");

    eeprom_set_a: assert property (@(posedge mclk_i) disable iff (rst_i) // [R05]
        evt2_i[`PIRQ_B2_EE_DONE] |=> eeprom_write_done_flag)
        else $error("EEPROM write flag not set.");

    coll1_set_a: assert property (@(posedge mclk_i) disable iff (rst_i) // [R05]
        evt2_i[`PIRQ_B2_COLL1] |=> port1_collision_flag)
        else $error("Port 1 collision flag not set.");

    cap2_set_a: assert property (@(posedge mclk_i) disable iff (rst_i) // [R06]
        LARGE_VARIANT && evt2_i[`PIRQ_B2_CAP2] |=> capture_unit2_flag)
        else $error("Capture 2 flag not set.");

    // Sources of the third register, large variant only.
    cap4_set_a: assert property (@(posedge mclk_i) disable iff (rst_i) // [R07]
        LARGE_VARIANT && evt3_i[`PIRQ_B3_CAP4] |=> capture_unit4_flag)
        else $error("Capture 4 flag not set.");

    cap3_set_a: assert property (@(posedge mclk_i) disable iff (rst_i) // [R07]
        LARGE_VARIANT && evt3_i[`PIRQ_B3_CAP3] |=> capture_unit3_flag)
        else $error("Capture 3 flag not set.");

    match6_set_a: assert property (@(posedge mclk_i) disable iff (rst_i) // [R07]
        LARGE_VARIANT && evt3_i[`PIRQ_B3_TMR6] |=> timer6_match_flag)
        else $error("Timer6 match flag not set.");

    match4_set_a: assert property (@(posedge mclk_i) disable iff (rst_i) // [R07]
        LARGE_VARIANT && evt3_i[`PIRQ_B3_TMR4] |=> timer4_match_flag)
        else $error("Timer4 match flag not set.");

    // Sources of the fourth register, large variant only.
    coll2_set_a: assert property (@(posedge mclk_i) disable iff (rst_i) // [R11]
        LARGE_VARIANT && evt4_i[`PIRQ_B4_COLL2] |=> port2_collision_flag)
        else $error("Port 2 collision flag not set.");

    sync2_set_a: assert property (@(posedge mclk_i) disable iff (rst_i) // [R11]
        LARGE_VARIANT && evt4_i[`PIRQ_B4_SYNC2] |=> sync_port2_flag)
        else $error("Sync port 2 flag not set.");

    // Register port and interrupt behaviour.
    tx_ro_a: assert property (@(posedge mclk_i) disable iff (rst_i) // [R04]
        wr_i && addr_i == `PIRQ_OFF_FLAGS1 && serial_tx_flag |=> serial_tx_flag)
        else $error("Read-only transmit flag was cleared.");

    unimpl2_rd_a: assert property (@(posedge mclk_i) disable iff (rst_i) // [R05]
        rd_i && addr_i == `PIRQ_OFF_FLAGS2 |=> (rdata_o & ~`PIRQ_IMPL2_LARGE) == 8'h00)
        else $error("Absent bit of flag register 2 read as one.");

    unimpl3_rd_a: assert property (@(posedge mclk_i) disable iff (rst_i) // [R07]
        rd_i && addr_i == `PIRQ_OFF_FLAGS3 |=> (rdata_o & ~`PIRQ_IMPL3_LARGE) == 8'h00)
        else $error("Absent bit of flag register 3 read as one.");

    unimpl4_rd_a: assert property (@(posedge mclk_i) disable iff (rst_i) // [R11]
        rd_i && addr_i == `PIRQ_OFF_FLAGS4 |=> (rdata_o & ~`PIRQ_IMPL4_LARGE) == 8'h00)
        else $error("Absent bit of flag register 4 read as one.");

    idle_rd_a: assert property (@(posedge mclk_i) disable iff (rst_i) // [R10]
        !rd_i |=> rdata_o == 8'h00)
        else $error("Read data present without a read.");

    mask_rd_a: assert property (@(posedge mclk_i) disable iff (rst_i) // [R01]
        rd_i && addr_i[2] |=> rdata_o == $past(mask_reg[addr_i[1:0]]))
        else $error("Mask read data mismatch.");

    mask_wr_a: assert property (@(posedge mclk_i) disable iff (rst_i) // [R01]
        wr_i && addr_i == `PIRQ_OFF_MASK2 |=> mask_reg[1] == ($past(wdata_i) & impl[1]))
        else $error("Mask write did not land.");

    irq_set_a: assert property (@(posedge mclk_i) disable iff (rst_i) // [R10]
        peripheral_irq_enable_i && pend_bits != 4'h0 |=> irq_o)
        else $error("Pending unmasked flag raised no interrupt.");

    irq_clear_a: assert property (@(posedge mclk_i) disable iff (rst_i) // [R10]
        pend_bits == 4'h0 |=> !irq_o)
        else $error("Interrupt raised with nothing pending.");

    clr_done_a: assert property (@(posedge mclk_i) disable iff (rst_i) // [R10]
        wr_i && addr_i == `PIRQ_OFF_FLAGS2 && evt2_i == 8'h00 |=> (flags_reg[1] & $past(wdata_i)) == 8'h00)
        else $error("Written one did not clear its flag.");

    clr_keep_a: assert property (@(posedge mclk_i) disable iff (rst_i) // [R10]
        wr_i && addr_i == `PIRQ_OFF_FLAGS2 && evt2_i == 8'h00 |=> flags_reg[1] == $past(flags_reg[1] & ~wdata_i))
        else $error("Written zero changed a flag.");

    osc_wins_a: assert property (@(posedge mclk_i) disable iff (rst_i) // [R13]
        wr_i && addr_i == `PIRQ_OFF_FLAGS2 && evt2_i[`PIRQ_B2_OSC_FAIL] |=> osc_fail_flag)
        else $error("Oscillator fail set lost against clear.");

    flags3_rd_a: assert property (@(posedge mclk_i) disable iff (rst_i) // [R07]
        rd_i && addr_i == `PIRQ_OFF_FLAGS3 |=> rdata_o == $past(flags_reg[2]))
        else $error("Flag register 3 read data mismatch.");

    flags4_rd_a: assert property (@(posedge mclk_i) disable iff (rst_i) // [R11]
        rd_i && addr_i == `PIRQ_OFF_FLAGS4 |=> rdata_o == $past(flags_reg[3]))
        else $error("Flag register 4 read data mismatch.");

endmodule

// *** rtl/pirq_consts.svh ***
`ifndef PIRQ_CONSTS_SVH
`define PIRQ_CONSTS_SVH

// Register indices on the plain register port.
`define PIRQ_ADDR_W        3
`define PIRQ_OFF_FLAGS1    3'h0
`define PIRQ_OFF_FLAGS2    3'h1
`define PIRQ_OFF_FLAGS3    3'h2
`define PIRQ_OFF_FLAGS4    3'h3
`define PIRQ_OFF_MASK1     3'h4
`define PIRQ_OFF_MASK2     3'h5
`define PIRQ_OFF_MASK3     3'h6
`define PIRQ_OFF_MASK4     3'h7

// Implemented bits of each flag register.
`define PIRQ_IMPL1_LARGE   8'hFF
`define PIRQ_IMPL2_LARGE   8'hF9
`define PIRQ_IMPL2_SMALL   8'hF8
`define PIRQ_IMPL3_LARGE   8'h3A
`define PIRQ_IMPL4_LARGE   8'h03
`define PIRQ_IMPL_NONE     8'h00

// Bits of the first flag register that software cannot write.
`define PIRQ_RO1           8'h30

// Field positions.
`define PIRQ_B1_TMR1_GATE  7
`define PIRQ_B1_CONV_DONE  6
`define PIRQ_B1_SER_RX     5
`define PIRQ_B1_SER_TX     4
`define PIRQ_B1_SYNC1      3
`define PIRQ_B1_CAP1       2
`define PIRQ_B1_TMR2       1
`define PIRQ_B1_TMR1_OVF   0
`define PIRQ_B2_OSC_FAIL   7
`define PIRQ_B2_CMP2       6
`define PIRQ_B2_CMP1       5
`define PIRQ_B2_EE_DONE    4
`define PIRQ_B2_COLL1      3
`define PIRQ_B2_CAP2       0
`define PIRQ_B3_CAP4       5
`define PIRQ_B3_CAP3       4
`define PIRQ_B3_TMR6       3
`define PIRQ_B3_TMR4       1
`define PIRQ_B4_COLL2      1
`define PIRQ_B4_SYNC2      0

`define PIRQ_FLAGS_RST     8'h00
`define PIRQ_MASK_RST      8'h00

`endif

// *** rtl/pirq_pkg.sv ***
package pirq_pkg;
    typedef logic [7:0] pirq_byte_t;
    typedef logic [3:0][7:0] pirq_bank_t;
endpackage

// *** sim/pirq_evt_src.sv ***
`timescale 1ns/1ps
module pirq_evt_src (
    // Clock and reset.
    input  wire logic          mclk_i,
    input  wire logic          rst_i,
    // Event pulses towards the flag bank.
    output pirq_pkg::pirq_bank_t evt_o
);
    initial evt_o = '0;

    // Sources stay quiet while the bank is being reset.
    always @(posedge rst_i) evt_o <= '0;

    // Each source raises its event for exactly one clock.
    task automatic pulse(input int r, input logic [7:0] b);
        @(posedge mclk_i);
        evt_o[r] <= b;
        @(posedge mclk_i);
        evt_o[r] <= 8'h00;
    endtask
endmodule

// *** sim/peripheral_irq_flag_bank_tb.sv ***
`timescale 1ns/1ps
`include "pirq_consts.svh"
module peripheral_irq_flag_bank_tb;
    logic                 mclk_i = 1'b0;
    logic                 rst_i = 1'b1;
    logic                 wr_i = 1'b0;
    logic                 rd_i = 1'b0;
    logic                 en_i = 1'b0;
    logic [2:0]           addr_i = 3'h0;
    logic [7:0]           wdata_i = 8'h00;
    logic [7:0]           rdata_o;
    logic                 irq_o;
    logic [7:0]           rdata_small;
    logic                 irq_small;
    pirq_pkg::pirq_bank_t evt;
    int                   n_errors = 0;
    int                   total_checks = 0;
    localparam logic [7:0] IMPL [4] = '{`PIRQ_IMPL1_LARGE, `PIRQ_IMPL2_LARGE, `PIRQ_IMPL3_LARGE, `PIRQ_IMPL4_LARGE};
    localparam logic [7:0] IMPL_S [4] = '{`PIRQ_IMPL1_LARGE, `PIRQ_IMPL2_SMALL, `PIRQ_IMPL_NONE, `PIRQ_IMPL_NONE};

    always #2.5 mclk_i = ~mclk_i;

    pirq_evt_src i_pirq_evt_src (.mclk_i(mclk_i), .rst_i(rst_i), .evt_o(evt));
    pirq_flag_bank #(.LARGE_VARIANT(1'b1)) i_pirq_flag_bank (
        .mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .evt1_i(evt[0]), .evt2_i(evt[1]), .evt3_i(evt[2]), .evt4_i(evt[3]),
        .peripheral_irq_enable_i(en_i), .irq_o(irq_o));
    pirq_flag_bank #(.LARGE_VARIANT(1'b0)) i_pirq_flag_bank_small (
        .mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_small), .evt1_i(evt[0]), .evt2_i(evt[1]), .evt3_i(evt[2]), .evt4_i(evt[3]),
        .peripheral_irq_enable_i(en_i), .irq_o(irq_small));

    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge mclk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1 chk("rdata", exp, rdata_o);
    endtask

    task automatic irq_chk(input logic exp);
        repeat (2) @(posedge mclk_i);
        #1 chk("irq", {7'h00, exp}, {7'h00, irq_o});
        chk("irq_small", {7'h00, exp}, {7'h00, irq_small});
    endtask

    task automatic test_done();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge mclk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 8; i++) rd(i[2:0], 8'h00);
        for (int i = 0; i < 4; i++) begin
            i_pirq_evt_src.pulse(i, 8'hFF);
            wr(i[2:0], 8'h00);
            rd(i[2:0], IMPL[i]);
            chk("rdata_small", IMPL_S[i], rdata_small);
        end
        irq_chk(1'b0);
        for (int i = 0; i < 4; i++) begin
            wr(i[2:0], 8'hFF);
            rd(i[2:0], (i == 0) ? `PIRQ_RO1 : 8'h00);
        end
        fork
            i_pirq_evt_src.pulse(0, 8'h80);
            wr(3'h0, 8'h80);
        join
        rd(3'h0, `PIRQ_RO1 | 8'h80);
        wr(3'h5, 8'h80);
        @(posedge mclk_i);
        en_i <= 1'b1;
        irq_chk(1'b0);
        fork
            i_pirq_evt_src.pulse(1, 8'h80);
            wr(3'h1, 8'h80);
        join
        rd(3'h1, 8'h80);
        irq_chk(1'b1);
        @(posedge mclk_i);
        en_i <= 1'b0;
        irq_chk(1'b0);
        i_pirq_evt_src.pulse(0, 8'h0F);
        @(posedge mclk_i);
        rst_i <= 1'b1;
        @(posedge mclk_i);
        rst_i <= 1'b0;
        rd(3'h0, 8'h00);
        rd(3'h1, 8'h00);
        rd(3'h5, 8'h00);
        test_done();
    end
endmodule
